// ===== pkg/ccw_cfg.svh
// Register map, field positions, reset values and limits of the compare timer.
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCW_OFF_CTRL  5'h00
`define CCW_OFF_COUNT 5'h04
`define CCW_OFF_CMP   5'h08
`define CCW_OFF_FLAGS 5'h0C
`define CCW_OFF_IRQEN 5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCW_CTRL_MODE_LO 0
`define CCW_CTRL_MODE_HI 1
`define CCW_CTRL_ACT_LO  2
`define CCW_CTRL_ACT_HI  3
`define CCW_CTRL_CS_LO   4
`define CCW_CTRL_CS_HI   6
`define CCW_CTRL_FORCE   7
`define CCW_FLG_OVF      0
`define CCW_FLG_CMP      1
`define CCW_FLG_OC       2

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define CCW_RST_BYTE 8'h00
`define CCW_RST_CS   3'h0
`define CCW_CNT_MAX  8'hFF
`define CCW_CNT_BOT  8'h00
`define CCW_ACT_NONE 2'h0
`define CCW_WORD_0   32'h0000_0000

`endif

// ===== pkg/ccw_pkg.sv
// Types shared by the compare timer design.
package ccw_pkg;

  // Waveform mode select encodings, in their hardware order.
  typedef enum logic [1:0] {
    CCW_NORMAL,
    CCW_PHASE,
    CCW_CLEAR_ON_MATCH,
    CCW_FAST_PWM
  } ccw_mode_t;

  // Compare output action encodings, in their hardware order.
  typedef enum logic [1:0] {
    CCW_ACT_OFF,
    CCW_ACT_TOGGLE,
    CCW_ACT_CLEAR,
    CCW_ACT_SET
  } ccw_act_t;

endpackage : ccw_pkg

// ===== src/ccw_timer.sv
// Eight-bit timer with compare output unit, waveform generator and pin override.
//
// Behaviour
// - Nonzero output action makes the pin carry the output state, not port data.
// - Pin direction still comes from the port direction bit.
// - Override depends on the action field only, never on the mode.
// - Output state can be preset, e.g. by forcing, before the pin is enabled.
// - Action zero leaves the output state untouched on matches.
// - A new action applies from the next match after the write.
// - Force strobe applies the action at once in non-PWM modes.
// - Counting depends on the mode field only.
// - Action means set/clear/toggle in non-PWM, polarity in fast PWM.
// - Normal mode counts up, wraps 0xFF to 0x00, never cleared.
// - Normal mode sets overflow flag as counter becomes zero; ack clears.
// - Clear-on-match mode returns counter to zero at the compare value.
// - Clear-on-match compare writes are direct; low values wrap through 0xFF.
// - Clear-on-match sets compare flag at each top match.
// - Clear-on-match toggle action gives half clock at compare zero.
// - Clear-on-match sets overflow flag on the 0xFF to 0x00 pass.
// - Fast PWM counts zero to 0xFF, then clears next tick.
// - Fast PWM action 2 clears on match, sets at bottom; 3 inverts.
// - Fast PWM sets overflow flag each time counter wraps from maximum to zero.
// - Fast PWM compare value is double buffered, loaded at the wrap.
// - Fast PWM compare at max holds output; at zero gives a spike.
// - Fast PWM toggle action gives a square wave of even duty.
// - Match sets compare flag next tick; ack or write-one clears.
// - Counter write blocks matches in the following timer tick.
// - Clock source zero stops timer; counter write beats count or clear.
// - Forced compare changes output only, not flag nor counter.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "ccw_cfg.svh"

module ccw_timer
  import ccw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        timer_tick,
  input  wire logic [4:0]  avm_address,
  input  wire logic        avm_read,
  input  wire logic        avm_write,
  input  wire logic [31:0] avm_writedata,
  input  wire logic [3:0]  avm_byteenable,
  output logic      [31:0] avm_readdata,
  output logic             avm_waitrequest,
  input  wire logic        port_out_val,
  input  wire logic        compare_pin_direction_bit,
  input  wire logic        overflow_ack,
  input  wire logic        compare_ack,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             overflow_irq_req,
  output logic             compare_irq_req
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Eight-bit increment with wrap, used by every counting mode.
  function automatic logic [7:0] ccw_inc(input logic [7:0] v);
    ccw_inc = v + 8'h01;
  endfunction : ccw_inc

  // Result of applying an action to the current output state.
  function automatic logic ccw_apply(input ccw_act_t a,
                                     input logic     cur);
    case (a)
      CCW_ACT_TOGGLE: ccw_apply = ~cur;
      CCW_ACT_CLEAR:  ccw_apply = 1'b0;
      CCW_ACT_SET:    ccw_apply = 1'b1;
      default:        ccw_apply = cur;
    endcase
  endfunction : ccw_apply

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccw_mode_t   mode_ff;
  ccw_act_t    act_ff;
  logic [2:0]  cs_ff;
  logic [7:0]  cnt_ff;
  logic [7:0]  cmp_buf_ff;
  logic [7:0]  cmp_act_ff;
  logic        ovf_ff;
  logic        cmpf_ff;
  logic        ovf_en_ff;
  logic        cmp_en_ff;
  logic        oc_ff;
  logic        blk_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        pin_ff;
  logic        oe_ff;
  logic        ovf_req_ff;
  logic        cmp_req_ff;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A request is committed in its second cycle, when waitrequest is low.
  wire req      = avm_read | avm_write;
  wire commit   = ce & req & ~wait_ff;
  wire wr_lane0 = commit & avm_write & avm_byteenable[0];
  wire sel_ctrl = avm_address == `CCW_OFF_CTRL;
  wire sel_cnt  = avm_address == `CCW_OFF_COUNT;
  wire sel_cmp  = avm_address == `CCW_OFF_CMP;
  wire sel_flg  = avm_address == `CCW_OFF_FLAGS;
  wire sel_ien  = avm_address == `CCW_OFF_IRQEN;
  wire ctrl_wr  = wr_lane0 & sel_ctrl;
  wire cnt_wr   = wr_lane0 & sel_cnt;
  wire cmp_wr   = wr_lane0 & sel_cmp;
  wire flg_wr   = wr_lane0 & sel_flg;
  wire ien_wr   = wr_lane0 & sel_ien;
  wire [7:0] wd = avm_writedata[7:0];

  // ----------------------------------------------------------------
  // Timer core decode
  // ----------------------------------------------------------------
  // Clock source zero stops the timer clock altogether.
  wire tick_en  = ce & timer_tick & (cs_ff != `CCW_RST_CS);
  wire is_fast  = mode_ff == CCW_FAST_PWM;
  wire is_ctc   = mode_ff == CCW_CLEAR_ON_MATCH;
  wire at_max   = cnt_ff == `CCW_CNT_MAX;
  wire match_raw = cnt_ff == cmp_act_ff;
  // Matches are lost for one tick after a counter write.
  wire match_ev = tick_en & match_raw & ~blk_ff & ~cnt_wr;
  // Wrap from max to bottom; in clear-on-match a match at max also wraps.
  wire wrap_ev  = tick_en & at_max & ~cnt_wr;
  // Force takes the mode and action written with it, so a single control
  // write can preset the output state before the pin is enabled.
  wire [1:0] wd_mode  = wd[`CCW_CTRL_MODE_HI:`CCW_CTRL_MODE_LO];
  wire [1:0] wd_act   = wd[`CCW_CTRL_ACT_HI:`CCW_CTRL_ACT_LO];
  wire force_go = ctrl_wr & wd[`CCW_CTRL_FORCE] & (wd_mode != CCW_FAST_PWM);

  // Counter next value: only the mode field shapes the sequence.
  wire [7:0] cnt_up = ccw_inc(cnt_ff);
  // A blocked match must not clear the counter either.
  wire       ctc_clr = is_ctc & match_raw & ~blk_ff;
  wire [7:0] nxt_cnt = cnt_wr  ? wd :
                       !tick_en ? cnt_ff :
                       ctc_clr ? `CCW_CNT_BOT : cnt_up;

  // Fast PWM compares against a buffered copy, loaded at the wrap.
  wire [7:0] nxt_cmp_act = (cmp_wr & ~is_fast) ? wd :
                           (is_fast & wrap_ev) ? cmp_buf_ff :
                           cmp_act_ff;

  // Output state next value. Fast PWM bottom wins over the match so a
  // compare value at max holds the output constant.
  wire oc_match = ccw_apply(act_ff, oc_ff);
  wire oc_force = ccw_apply(ccw_act_t'(wd_act), oc_ff);
  wire pwm_pol  = act_ff == CCW_ACT_CLEAR;
  wire pwm_mode = is_fast & (act_ff == CCW_ACT_CLEAR | act_ff == CCW_ACT_SET);
  logic nxt_oc;
  always_comb begin
    nxt_oc = oc_ff;
    if (pwm_mode & wrap_ev) begin
      nxt_oc = pwm_pol;
    end else if (pwm_mode & match_ev) begin
      nxt_oc = ~pwm_pol;
    end else if (match_ev) begin
      nxt_oc = oc_match;
    end else if (force_go) begin
      nxt_oc = oc_force;
    end
  end

  // Flags: hardware set wins over a software or acknowledge clear.
  wire ovf_clr  = overflow_ack | (flg_wr & wd[`CCW_FLG_OVF]);
  wire cmp_clr  = compare_ack | (flg_wr & wd[`CCW_FLG_CMP]);
  wire nxt_ovf  = wrap_ev | (ovf_ff & ~ovf_clr);
  wire nxt_cmpf = match_ev | (cmpf_ff & ~cmp_clr);

  // Block stays armed until a timer tick passes, even while stopped.
  wire nxt_blk = cnt_wr | (blk_ff & ~tick_en);

  // Read data mux; unmapped offsets read as zero.
  wire [31:0] nxt_rdata =
    sel_ctrl ? {24'h0, 1'b0, cs_ff, act_ff, mode_ff} :
    sel_cnt  ? {24'h0, cnt_ff} :
    sel_cmp  ? {24'h0, cmp_buf_ff} :
    sel_flg  ? {29'h0, oc_ff, cmpf_ff, ovf_ff} :
    sel_ien  ? {30'h0, cmp_en_ff, ovf_en_ff} : `CCW_WORD_0;

  // Pin source chosen by the action field alone, never by the mode.
  wire nxt_pin = (act_ff != CCW_ACT_OFF) ? oc_ff : port_out_val;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data registered.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff  <= 1'b1;
      rdata_ff <= `CCW_WORD_0;
    end else if (ce) begin
      wait_ff  <= ~(req & wait_ff);
      rdata_ff <= (req & avm_read) ? nxt_rdata : `CCW_WORD_0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Mode and action reset to normal mode with the pin left to the port.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= CCW_NORMAL;
      act_ff  <= CCW_ACT_OFF;
      cs_ff   <= `CCW_RST_CS;
    end else if (ctrl_wr) begin
      mode_ff <= ccw_mode_t'(wd[`CCW_CTRL_MODE_HI:`CCW_CTRL_MODE_LO]);
      act_ff  <= ccw_act_t'(wd[`CCW_CTRL_ACT_HI:`CCW_CTRL_ACT_LO]);
      cs_ff   <= wd[`CCW_CTRL_CS_HI:`CCW_CTRL_CS_LO];
    end
  end

  // Interrupt request enables.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_en_ff <= 1'b0;
      cmp_en_ff <= 1'b0;
    end else if (ien_wr) begin
      ovf_en_ff <= wd[`CCW_FLG_OVF];
      cmp_en_ff <= wd[`CCW_FLG_CMP];
    end
  end

  // Compare buffer always takes software writes; readback shows it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_buf_ff <= `CCW_RST_BYTE;
    end else if (cmp_wr) begin
      cmp_buf_ff <= wd;
    end
  end

  // ----------------------------------------------------------------
  // Timer core
  // ----------------------------------------------------------------
  // Counter, active compare, flags, output state and match block.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff     <= `CCW_RST_BYTE;
      cmp_act_ff <= `CCW_RST_BYTE;
      ovf_ff     <= 1'b0;
      cmpf_ff    <= 1'b0;
      oc_ff      <= 1'b0;
      blk_ff     <= 1'b0;
    end else if (ce) begin
      cnt_ff     <= nxt_cnt;
      cmp_act_ff <= nxt_cmp_act;
      ovf_ff     <= nxt_ovf;
      cmpf_ff    <= nxt_cmpf;
      oc_ff      <= nxt_oc;
      blk_ff     <= nxt_blk;
    end
  end

  // ----------------------------------------------------------------
  // Pin and request outputs
  // ----------------------------------------------------------------
  // Registered so every output leaves from a flip-flop; pin outputs lag one cycle, requests track the flags.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ff     <= 1'b0;
      oe_ff      <= 1'b0;
      ovf_req_ff <= 1'b0;
      cmp_req_ff <= 1'b0;
    end else if (ce) begin
      pin_ff     <= nxt_pin;
      oe_ff      <= compare_pin_direction_bit;
      ovf_req_ff <= nxt_ovf & ovf_en_ff;
      cmp_req_ff <= nxt_cmpf & cmp_en_ff;
    end
  end

  assign avm_readdata     = rdata_ff;
  assign avm_waitrequest  = wait_ff;
  assign pin_out          = pin_ff;
  assign pin_oe           = oe_ff;
  assign overflow_irq_req = ovf_req_ff;
  assign compare_irq_req  = cmp_req_ff;

  // Assertion helper: a counter write stays pending until a timer tick passes.
  logic chk_wr_pend_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_wr_pend_ff <= 1'b0;
    end else if (ce) begin
      chk_wr_pend_ff <= cnt_wr | (chk_wr_pend_ff & ~tick_en);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Pin carries the output state whenever an action is selected.
  a_pin_source: assert property (
    ce && act_ff != CCW_ACT_OFF |=> pin_out == $past(oc_ff))
    else $error("pin not driven by output state");

  // Pin enable follows the port direction bit.
  a_pin_dir: assert property (
    ce |=> pin_oe == $past(compare_pin_direction_bit))
    else $error("pin enable not from direction bit");

  // Without a force, action zero never changes the output state.
  a_act_zero: assert property (
    ce && act_ff == CCW_ACT_OFF && !is_fast && !force_go |=> oc_ff == $past(oc_ff))
    else $error("output state changed with action off");

  // Wrap through max sets the overflow flag.
  a_ovf_set: assert property (
    tick_en && at_max && !cnt_wr |=> ovf_ff && cnt_ff == `CCW_CNT_BOT)
    else $error("overflow flag not set at wrap");

  // Clear-on-match returns the counter to zero at the compare value.
  a_ctc_clear: assert property (
    tick_en && is_ctc && match_raw && !blk_ff && !cnt_wr |=> cnt_ff == `CCW_CNT_BOT)
    else $error("counter not cleared on match");

  // A match sets the compare flag on the next cycle.
  a_cmp_flag: assert property (
    match_ev |=> cmpf_ff)
    else $error("compare flag not set after match");

  // Neither the write edge nor the first tick after a counter write sets the flag.
  a_wr_block: assert property (
    (cnt_wr || (tick_en && chk_wr_pend_ff)) && !cmpf_ff |=> !cmpf_ff)
    else $error("match not blocked after counter write");

  // Fast PWM non-inverted output is high after the wrap.
  a_pwm_bottom: assert property (
    tick_en && is_fast && act_ff == CCW_ACT_CLEAR && at_max && !cnt_wr
    |=> oc_ff)
    else $error("fast pwm output not set at bottom");

  // A forced compare leaves a stopped counter alone.
  a_force_cnt: assert property (
    force_go && !tick_en && !cnt_wr |=> $stable(cnt_ff))
    else $error("forced compare moved the counter");

  // Every request is answered one cycle after it is presented.
  a_bus_answer: assert property (
    ce && req && avm_waitrequest |=> !avm_waitrequest)
    else $error("waitrequest not released");

  // With no action the pin shows the port value.
  a_pin_port: assert property (
    ce && act_ff == CCW_ACT_OFF |=> pin_out == $past(port_out_val))
    else $error("pin not driven by port value");

  // A forced set drives the output state high at once.
  a_force_set: assert property (
    force_go && wd_act == CCW_ACT_SET && !match_ev |=> oc_ff)
    else $error("forced set did not reach output state");

  // A forced compare never raises the compare flag.
  a_force_flag: assert property (
    force_go && !match_ev && !cmpf_ff |=> !cmpf_ff)
    else $error("forced compare set the compare flag");

  // In fast PWM the active compare value only moves at the wrap.
  a_cmp_hold: assert property (
    ce && is_fast && !wrap_ev |=> $stable(cmp_act_ff))
    else $error("active compare changed outside the wrap");

  // Clear-on-match raises the compare flag at the top.
  a_ctc_top: assert property (
    tick_en && is_ctc && match_raw && !blk_ff && !cnt_wr |=> cmpf_ff)
    else $error("compare flag not set at top");

  // Fast PWM non-inverted output clears on a match below max.
  a_pwm_match: assert property (
    tick_en && is_fast && act_ff == CCW_ACT_CLEAR && match_raw && !blk_ff
    && !cnt_wr && !at_max |=> !oc_ff)
    else $error("fast pwm output not cleared at match");

  // A stopped timer keeps its count unless software writes it.
  a_stopped: assert property (
    ce && cs_ff == `CCW_RST_CS && !cnt_wr |=> $stable(cnt_ff))
    else $error("stopped counter moved");

endmodule : ccw_timer

// ===== sim/ccw_pin_model.sv
// External pin model: resolves the compare pin level seen on the board.
`timescale 1ns/1ps

module ccw_pin_model (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // A board pull-up holds the line high while the block does not drive it,
  // so a released pin never shows a stale drive value.
  assign pin_level = pin_oe ? pin_out : 1'h1;
endmodule : ccw_pin_model

// ===== sim/ccw_timer_tb.sv
// Self-checking testbench of the compare timer.
`timescale 1ns/1ps
`include "ccw_cfg.svh"

module ccw_timer_tb
  import ccw_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        ce = 1'h1;
  logic        timer_tick = 1'h0;
  logic [4:0]  avm_address = 5'h00;
  logic        avm_read = 1'h0;
  logic        avm_write = 1'h0;
  logic [31:0] avm_writedata = 32'h0;
  logic [3:0]  avm_byteenable = 4'hF;
  logic [31:0] avm_readdata;
  logic        avm_waitrequest;
  logic        port_out_val = 1'h0;
  logic        compare_pin_direction_bit = 1'h0;
  logic        overflow_ack = 1'h0;
  logic        compare_ack = 1'h0;
  logic        pin_out;
  logic        pin_oe;
  logic        pin_level;
  logic        overflow_irq_req;
  logic        compare_irq_req;
  int          miscompares = 0;
  int          n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  ccw_timer i_ccw_timer (.ref_clk, .rst_n, .ce, .timer_tick, .avm_address, .avm_read,
    .avm_write, .avm_writedata, .avm_byteenable, .avm_readdata, .avm_waitrequest,
    .port_out_val, .compare_pin_direction_bit, .overflow_ack, .compare_ack, .pin_out,
    .pin_oe, .overflow_irq_req, .compare_irq_req);

  ccw_pin_model i_ccw_pin_model (.pin_out, .pin_oe, .pin_level);

  // ----------------------------------------------------------------
  // Bus, tick and check tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // The request stands until waitrequest is sampled low; no latency is assumed.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge ref_clk);
    avm_read <= ~wr;
    avm_write <= wr;
    avm_address <= a;
    avm_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avm_waitrequest !== 1'h0);
    q = avm_readdata;
    avm_read <= 1'h0;
    avm_write <= 1'h0;
  endtask : bus

  task wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr

  task rd(input logic [4:0] a, input string nm, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask : rd

  // Control word: force strobe, clock source, output action, mode.
  function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] act,
                                     input logic [2:0] cs, input logic frc);
    return {24'h0, frc, cs, act, m};
  endfunction : cw

  // Gives exactly n timer ticks on consecutive edges.
  task tk(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      timer_tick <= 1'h1;
    end
    @(posedge ref_clk);
    timer_tick <= 1'h0;
  endtask : tk

  task pin(input logic oe, input logic lvl);
    repeat (3) @(posedge ref_clk);
    chk("pin_oe", {31'h0, oe}, {31'h0, pin_oe});
    chk("pin_level", {31'h0, lvl}, {31'h0, pin_level});
  endtask : pin

  task ack(input logic ovf);
    @(posedge ref_clk);
    overflow_ack <= ovf;
    compare_ack <= ~ovf;
    @(posedge ref_clk);
    overflow_ack <= 1'h0;
    compare_ack <= 1'h0;
  endtask : ack

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(`CCW_OFF_CTRL, "ctrl", 32'h0);
    rd(5'h14, "unmapped", 32'h0);
    port_out_val <= 1'h1;
    compare_pin_direction_bit <= 1'h1;
    pin(1'h1, 1'h1);
    port_out_val <= 1'h0;
    pin(1'h1, 1'h0);
  endtask : t_reset

  // Forcing presets the output state while the pin is still an input.
  task t_force;
    compare_pin_direction_bit <= 1'h0;
    port_out_val <= 1'h1;
    wr(`CCW_OFF_CTRL, cw(CCW_NORMAL, CCW_ACT_CLEAR, 3'h0, 1'h1));
    rd(`CCW_OFF_FLAGS, "flags", 32'h0);
    pin(1'h0, 1'h1);
    wr(`CCW_OFF_CTRL, cw(CCW_NORMAL, CCW_ACT_SET, 3'h0, 1'h1));
    rd(`CCW_OFF_FLAGS, "flags", 32'h4);
    rd(`CCW_OFF_COUNT, "count", 32'h0);
    wr(`CCW_OFF_CTRL, cw(CCW_NORMAL, CCW_ACT_OFF, 3'h0, 1'h1));
    rd(`CCW_OFF_FLAGS, "flags", 32'h4);
    wr(`CCW_OFF_CTRL, cw(CCW_NORMAL, CCW_ACT_TOGGLE, 3'h0, 1'h1));
    rd(`CCW_OFF_FLAGS, "flags", 32'h0);
    compare_pin_direction_bit <= 1'h1;
    pin(1'h1, 1'h0);
  endtask : t_force

  task t_normal;
    wr(`CCW_OFF_COUNT, 32'hFE);
    wr(`CCW_OFF_CTRL, cw(CCW_NORMAL, CCW_ACT_OFF, 3'h0, 1'h0));
    tk(3);
    rd(`CCW_OFF_COUNT, "count", 32'hFE);
    wr(`CCW_OFF_IRQEN, 32'h1);
    wr(`CCW_OFF_CTRL, cw(CCW_NORMAL, CCW_ACT_OFF, 3'h1, 1'h0));
    tk(2);
    rd(`CCW_OFF_COUNT, "count", 32'h0);
    rd(`CCW_OFF_FLAGS, "flags", 32'h1);
    chk("ovf_irq", 32'h1, {31'h0, overflow_irq_req});
    ack(1'h1);
    rd(`CCW_OFF_FLAGS, "flags", 32'h0);
  endtask : t_normal

  task t_ctc;
    wr(`CCW_OFF_CTRL, cw(CCW_CLEAR_ON_MATCH, CCW_ACT_OFF, 3'h0, 1'h0));
    wr(`CCW_OFF_CMP, 32'h3);
    wr(`CCW_OFF_IRQEN, 32'h2);
    wr(`CCW_OFF_CTRL, cw(CCW_CLEAR_ON_MATCH, CCW_ACT_TOGGLE, 3'h1, 1'h0));
    tk(4);
    rd(`CCW_OFF_COUNT, "count", 32'h0);
    rd(`CCW_OFF_FLAGS, "flags", 32'h6);
    chk("cmp_irq", 32'h1, {31'h0, compare_irq_req});
    ack(1'h0);
    rd(`CCW_OFF_FLAGS, "flags", 32'h4);
    wr(`CCW_OFF_CMP, 32'h0);
    tk(3);
    rd(`CCW_OFF_FLAGS, "flags", 32'h2);
    wr(`CCW_OFF_FLAGS, 32'h2);
    rd(`CCW_OFF_FLAGS, "flags", 32'h0);
  endtask : t_ctc

  task t_ctc_low;
    wr(`CCW_OFF_CTRL, cw(CCW_CLEAR_ON_MATCH, CCW_ACT_OFF, 3'h0, 1'h0));
    wr(`CCW_OFF_CMP, 32'h4);
    wr(`CCW_OFF_COUNT, 32'h4);
    wr(`CCW_OFF_CTRL, cw(CCW_CLEAR_ON_MATCH, CCW_ACT_OFF, 3'h1, 1'h0));
    tk(1);
    rd(`CCW_OFF_COUNT, "count", 32'h5);
    wr(`CCW_OFF_CMP, 32'h2);
    tk(250);
    rd(`CCW_OFF_FLAGS, "flags", 32'h0);
    tk(1);
    rd(`CCW_OFF_FLAGS, "flags", 32'h1);
    tk(3);
    rd(`CCW_OFF_COUNT, "count", 32'h0);
    rd(`CCW_OFF_FLAGS, "flags", 32'h3);
  endtask : t_ctc_low

  // The second compare write must wait in the buffer until the wrap.
  task t_pwm;
    wr(`CCW_OFF_FLAGS, 32'h3);
    wr(`CCW_OFF_CTRL, cw(CCW_CLEAR_ON_MATCH, CCW_ACT_OFF, 3'h0, 1'h0));
    wr(`CCW_OFF_CMP, 32'h10);
    wr(`CCW_OFF_COUNT, 32'hFD);
    wr(`CCW_OFF_CTRL, cw(CCW_FAST_PWM, CCW_ACT_CLEAR, 3'h1, 1'h0));
    wr(`CCW_OFF_CMP, 32'hFE);
    tk(2);
    rd(`CCW_OFF_COUNT, "count", 32'hFF);
    rd(`CCW_OFF_FLAGS, "flags", 32'h0);
    wr(`CCW_OFF_CMP, 32'h2);
    tk(1);
    rd(`CCW_OFF_COUNT, "count", 32'h0);
    rd(`CCW_OFF_FLAGS, "flags", 32'h5);
    wr(`CCW_OFF_FLAGS, 32'h1);
    tk(3);
    rd(`CCW_OFF_FLAGS, "flags", 32'h2);
    pin(1'h1, 1'h0);
    wr(`CCW_OFF_CTRL, cw(CCW_FAST_PWM, CCW_ACT_SET, 3'h1, 1'h0));
    tk(256);
    rd(`CCW_OFF_FLAGS, "flags", 32'h7);
    rd(`CCW_OFF_COUNT, "count", 32'h3);
    pin(1'h1, 1'h1);
  endtask : t_pwm

  // ----------------------------------------------------------------
  // Run and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_reset();
    t_force();
    t_normal();
    t_ctc();
    t_ctc_low();
    t_pwm();
    test_done();
  end

  // The run needs about 740 cycles; this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
endmodule : ccw_timer_tb
